/* File: hw/cdir_coherence_directory.v */
/*
  Coherence directory (snoop filter) with two address-interleaved tag arrays,
  SEC-DED protected entries, active-way/invalid-first replacement, a request
  arbiter for four processor buses plus coherent I/O and a fast clear.
  Assumes requesters and the init strobe are logic on the same clock, which
  is the filter clock at twice the core rate; a requester holds its request
  until it sees its grant bit.
*/
`timescale 1ns/100ps
`include "cdir_map.vh"

module cdir_coherence_directory (
  input wire clock,
  input wire arst_n,
  input wire [`CDIR_NUM_REQ-1:0] req_valid,
  input wire [2*`CDIR_NUM_REQ-1:0] req_op,
  input wire [`CDIR_ADDR_W*`CDIR_NUM_REQ-1:0] req_addr,
  input wire [3*`CDIR_NUM_REQ-1:0] req_group,
  input wire [`CDIR_PV_W*`CDIR_NUM_REQ-1:0] req_pv,
  input wire [`CDIR_NUM_REQ-1:0] req_em,
  output wire [`CDIR_NUM_REQ-1:0] req_grant,
  input wire init_start,
  output wire init_busy,
  output wire [1:0] resp_valid,
  output wire [5:0] resp_src,
  output wire [1:0] resp_hit,
  output wire [13:0] resp_slot,
  output wire [7:0] resp_pv,
  output wire [1:0] resp_em,
  output wire [1:0] resp_evict,
  output wire [79:0] resp_evict_addr,
  output wire [7:0] resp_evict_pv,
  output wire [1:0] ecc_sbe,
  output wire [1:0] ecc_dbe
);

  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_DRAIN = 3'h2;
  localparam [2:0] ST_CLEAR = 3'h4;

  // SEC-DED encode: Hamming positions 1..34, overall parity in bit 0
  function [`CDIR_ENT_W-1:0] cdir_ecc_enc;
    input [`CDIR_DATA_W-1:0] d;
    integer p, k, i;
    reg par;
    reg [`CDIR_ENT_W-1:0] c;
    begin
      c = {`CDIR_ENT_W{1'b0}};
      k = 0;
      for (p = 1; p < `CDIR_ENT_W; p = p + 1)
        if ((p & (p - 1)) != 0)
        begin
          c[p] = d[k];
          k = k + 1;
        end
      for (i = 0; i < 6; i = i + 1)
      begin
        par = 1'b0;
        for (p = 1; p < `CDIR_ENT_W; p = p + 1)
          if (((p >> i) & 1) == 1)
            par = par ^ c[p];
        c[1 << i] = par;
      end
      c[0] = ^c[`CDIR_ENT_W-1:1];
      cdir_ecc_enc = c;
    end
  endfunction

  // SEC-DED check: returns {double, single, corrected data}
  function [`CDIR_DATA_W+1:0] cdir_ecc_fix;
    input [`CDIR_ENT_W-1:0] c;
    integer p, k, i;
    reg [5:0] s;
    reg [`CDIR_ENT_W-1:0] f;
    reg [`CDIR_DATA_W-1:0] d;
    reg sbe, dbe;
    begin
      s = 6'h00;
      for (i = 0; i < 6; i = i + 1)
        for (p = 1; p < `CDIR_ENT_W; p = p + 1)
          if (((p >> i) & 1) == 1)
            s[i] = s[i] ^ c[p];
      f = c;
      sbe = 1'b0;
      dbe = 1'b0;
      if (^c && s < 6'h23)
      begin
        sbe = 1'b1;
        f[s] = ~f[s];
      end
      else if (^c || s != 6'h00)
        dbe = 1'b1;
      k = 0;
      d = {`CDIR_DATA_W{1'b0}};
      for (p = 1; p < `CDIR_ENT_W; p = p + 1)
        if ((p & (p - 1)) != 0)
        begin
          d[k] = f[p];
          k = k + 1;
        end
      cdir_ecc_fix = {dbe, sbe, d};
    end
  endfunction

  // Random table of 1024 words; a fixed scramble of the index, read only
  function [15:0] cdir_rand;
    input [`CDIR_ROM_IDX_W-1:0] a;
    reg [15:0] x;
    begin
      x = {a[5:0], a} ^ {a, a[9:4]} ^ 16'hA5C3;
      cdir_rand = x ^ {x[10:0], x[15:11]};
    end
  endfunction

  function [2:0] cdir_weight;
    input [2:0] r;
    begin
      cdir_weight = (r == `CDIR_IO_REQ) ? `CDIR_WEIGHT_IO : `CDIR_WEIGHT_BUS;
    end
  endfunction

  reg [`CDIR_NUM_REQ-1:0] req_grant_reg;
  reg [2:0] rr_ptr_reg, rr_ptr_next;
  reg [2:0] credit_reg, credit_next;
  reg [2:0] st_reg;
  reg init_busy_reg;
  reg [`CDIR_SET_W-1:0] init_cnt_reg;
  reg [`CDIR_ROM_IDX_W-1:0] rnd_idx_reg;
  reg found;
  reg [2:0] gidx;
  wire [`CDIR_NUM_REQ-1:0] req_elig;
  wire [1:0] il_v0, il_v1, il_busy;
  wire [2*`CDIR_SET_W-1:0] il_set1;
  wire init_clear = (st_reg == ST_CLEAR);
  wire [15:0] rnd = cdir_rand(rnd_idx_reg);
  wire [`CDIR_RQ_W-1:0] sel_rq;

  assign req_grant = req_grant_reg;
  assign init_busy = init_busy_reg;

  // A requester is eligible if its interleave can take a new read now
  genvar i;
  generate
    for (i = 0; i < `CDIR_NUM_REQ; i = i + 1)
    begin : g_req
      wire il = req_addr[i*`CDIR_ADDR_W+`CDIR_ILV_BIT];
      wire [`CDIR_SET_W-1:0] rset = req_addr[i*`CDIR_ADDR_W+`CDIR_SET_LSB +: `CDIR_SET_W];
      // Same-set read may not meet the earlier write of that set
      assign req_elig[i] = req_valid[i] & ~req_grant_reg[i] & ~init_busy_reg & ~il_v0[il] &
        ~(il_v1[il] & (il_set1[il*`CDIR_SET_W +: `CDIR_SET_W] == rset));
    end
  endgenerate

  // Weighted round-robin: the pointer keeps its holder for weight grants
  always @*
  begin : p_arb
    integer k, idx;
    idx = 0;
    found = 1'b0;
    gidx = 3'h0;
    rr_ptr_next = rr_ptr_reg;
    credit_next = credit_reg;
    for (k = 0; k < `CDIR_NUM_REQ; k = k + 1)
    begin
      idx = rr_ptr_reg + k;
      if (idx >= `CDIR_NUM_REQ)
        idx = idx - `CDIR_NUM_REQ;
      if (!found && req_elig[idx])
      begin
        found = 1'b1;
        gidx = idx[2:0];
      end
    end
    if (found)
    begin
      if (gidx == rr_ptr_reg && credit_reg > 3'h1)
        credit_next = credit_reg - 3'h1;
      else if (gidx != rr_ptr_reg && cdir_weight(gidx) > 3'h1)
      begin
        rr_ptr_next = gidx;
        credit_next = cdir_weight(gidx) - 3'h1;
      end
      else
      begin
        rr_ptr_next = (gidx == `CDIR_IO_REQ) ? 3'h0 : gidx + 3'h1;
        credit_next = cdir_weight(rr_ptr_next);
      end
    end
  end

  assign sel_rq = {req_op[gidx*2 +: 2], req_addr[gidx*`CDIR_ADDR_W +: `CDIR_ADDR_W],
    req_group[gidx*3 +: 3], req_pv[gidx*`CDIR_PV_W +: `CDIR_PV_W], req_em[gidx], gidx};

  // Grant pulse, arbiter state and random index
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_grant_reg <= 5'h00;
      rr_ptr_reg <= 3'h0;
      credit_reg <= `CDIR_WEIGHT_BUS;
      rnd_idx_reg <= 10'h000;
    end
    else
    begin
      req_grant_reg <= found ? (5'h01 << gidx) : 5'h00;
      rr_ptr_reg <= rr_ptr_next;
      credit_reg <= credit_next;
      rnd_idx_reg <= rnd_idx_reg + 10'h001;
    end
  end

  // Fast clear: wait for the pipelines to empty, then zero one set per clock
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= ST_IDLE;
      init_busy_reg <= 1'b0;
      init_cnt_reg <= 12'h000;
    end
    else
    begin
      case (st_reg)
        ST_IDLE:
          if (init_start)
          begin
            st_reg <= ST_DRAIN;
            init_busy_reg <= 1'b1;
          end
        ST_DRAIN:
          if (il_busy == 2'h0)
          begin
            st_reg <= ST_CLEAR;
            init_cnt_reg <= 12'h000;
          end
        ST_CLEAR:
        begin
          init_cnt_reg <= init_cnt_reg + 12'h001;
          if (init_cnt_reg == `CDIR_LAST_SET)
          begin
            st_reg <= ST_IDLE;
            init_busy_reg <= 1'b0;
          end
        end
        default:
          st_reg <= ST_IDLE;
      endcase
    end
  end

  genvar j, e;
  generate
    for (j = 0; j < `CDIR_NUM_ILV; j = j + 1)
    begin : g_ilv
      // One word per set holds all 128 protected entries
      reg [`CDIR_SET_WORD_W-1:0] tag_mem [0:`CDIR_NUM_SETS-1];
      reg [`CDIR_VIC_WORD_W-1:0] vic_mem [0:`CDIR_NUM_SETS-1];
      reg [3:0] v_reg;
      reg [`CDIR_RQ_W-1:0] rq0_reg, rq1_reg, rq2_reg;
      reg [`CDIR_SET_WORD_W-1:0] rd_word_reg, wr_word_reg, new_word;
      reg [`CDIR_VIC_WORD_W-1:0] rd_vic_reg, wr_vic_reg, new_vic;
      reg [`CDIR_SET_W-1:0] wr_set_reg;
      reg [62:0] res_reg, res_next;
      reg rv_reg, sbe_reg, dbe_reg;
      reg [62:0] out_reg;
      wire acc = found & (sel_rq[`CDIR_RQ_ADDR+`CDIR_ILV_BIT] == j);
      wire [`CDIR_SLOT_N-1:0] e_hit, e_free, e_sbe, e_dbe;
      wire [`CDIR_DATA_W*`CDIR_SLOT_N-1:0] e_data;
      wire [`CDIR_SET_WORD_W-1:0] fix_word;
      wire [`CDIR_SET_W-1:0] set1 = rq1_reg[`CDIR_RQ_ADDR+`CDIR_SET_LSB +: `CDIR_SET_W];
      wire [`CDIR_SET_W-1:0] set2 = rq2_reg[`CDIR_RQ_ADDR+`CDIR_SET_LSB +: `CDIR_SET_W];
      wire [`CDIR_TAG_W-1:0] tag2 = rq2_reg[`CDIR_RQ_ADDR+`CDIR_TAG_LSB +: `CDIR_TAG_W];

      assign il_v0[j] = v_reg[0];
      assign il_v1[j] = v_reg[1];
      assign il_busy[j] = |v_reg;
      assign il_set1[j*`CDIR_SET_W +: `CDIR_SET_W] = set1;

      // Check and correct every entry; rewriting the set scrubs single errors
      for (e = 0; e < `CDIR_SLOT_N; e = e + 1)
      begin : g_ent
        wire [`CDIR_DATA_W+1:0] dec = cdir_ecc_fix(rd_word_reg[e*`CDIR_ENT_W +: `CDIR_ENT_W]);
        wire ent_valid = ~dec[`CDIR_DATA_W+1] & (|dec[`CDIR_F_PV +: `CDIR_PV_W]);
        assign e_sbe[e] = dec[`CDIR_DATA_W];
        assign e_dbe[e] = dec[`CDIR_DATA_W+1];
        assign e_data[e*`CDIR_DATA_W +: `CDIR_DATA_W] = dec[`CDIR_DATA_W-1:0];
        assign e_hit[e] = ent_valid & (dec[`CDIR_F_TAG +: `CDIR_TAG_W] == tag2);
        assign e_free[e] = ~ent_valid;
        assign fix_word[e*`CDIR_ENT_W +: `CDIR_ENT_W] = cdir_ecc_enc(dec[`CDIR_DATA_W-1:0]);
      end

      // Lookup-update: decide hit, allocation, eviction and replacement state
      always @*
      begin : p_comp
        integer s;
        reg hit, ffound, wen, ven, ev, em_st;
        reg [6:0] h_slot, wslot;
        reg [3:0] fway, way, pvin;
        reg [2:0] grp, vg;
        reg [1:0] op;
        reg [7:0] vbyte;
        reg [`CDIR_DATA_W-1:0] hdat, edat, wdata;
        hit = 1'b0;
        h_slot = 7'h00;
        ffound = 1'b0;
        fway = 4'h0;
        wen = 1'b0;
        ven = 1'b0;
        ev = 1'b0;
        wslot = 7'h00;
        vg = 3'h0;
        way = 4'h0;
        wdata = 28'h0000000;
        hdat = 28'h0000000;
        edat = 28'h0000000;
        em_st = 1'b0;
        vbyte = 8'h00;
        grp = rq2_reg[`CDIR_RQ_GRP +: 3];
        op = rq2_reg[`CDIR_RQ_OP +: 2];
        pvin = rq2_reg[`CDIR_RQ_PV +: `CDIR_PV_W];
        for (s = `CDIR_SLOT_N - 1; s >= 0; s = s - 1)
          if (e_hit[s])
          begin
            hit = 1'b1;
            h_slot = s[6:0];
          end
        for (s = `CDIR_NUM_WAYS - 1; s >= 0; s = s - 1)
          if (e_free[grp*`CDIR_NUM_WAYS+s])
          begin
            ffound = 1'b1;
            fway = s[3:0];
          end
        hdat = e_data[h_slot*`CDIR_DATA_W +: `CDIR_DATA_W];
        // Flag kept only with at most one presence bit
        em_st = rq2_reg[`CDIR_RQ_EM] & ((pvin & (pvin - 4'h1)) == 4'h0);
        if (op == `CDIR_OP_UPDATE && pvin == 4'h0)
          op = `CDIR_OP_INVAL;
        if (op == `CDIR_OP_UPDATE && !hit)
        begin
          // Miss: invalid way of own group first, else its active-way victim
          way = ffound ? fway : rd_vic_reg[grp*`CDIR_VIC_W +: 4];
          wslot = {grp, way};
          ev = ~ffound;
          vg = grp;
        end
        else
        begin
          way = h_slot[3:0];
          wslot = h_slot;
          vg = h_slot[6:4];
        end
        edat = e_data[wslot*`CDIR_DATA_W +: `CDIR_DATA_W];
        if (op == `CDIR_OP_UPDATE)
        begin
          wen = 1'b1;
          wdata = {2'h0, em_st, pvin, tag2};
        end
        else if (op == `CDIR_OP_INVAL)
          wen = hit;
        ven = hit | (op == `CDIR_OP_UPDATE);
        // Active way moves past the used way by a random stride
        vbyte = {rnd[7:4], way + 4'h1 + {1'b0, rd_vic_reg[vg*`CDIR_VIC_W+4 +: 3]}};
        if (op == `CDIR_OP_INVAL)
          vbyte = {rd_vic_reg[vg*`CDIR_VIC_W+4 +: 4], way};
        new_word = fix_word;
        new_vic = rd_vic_reg;
        if (wen)
          new_word[wslot*`CDIR_ENT_W +: `CDIR_ENT_W] = cdir_ecc_enc(wdata);
        if (ven)
          new_vic[vg*`CDIR_VIC_W +: `CDIR_VIC_W] = vbyte;
        res_next = {hit, h_slot, hdat[`CDIR_F_PV +: 4], hdat[`CDIR_F_EM], ev,
          edat[`CDIR_F_TAG +: `CDIR_TAG_W], set2, (j == 1) ? 1'b1 : 1'b0, 6'h00,
          edat[`CDIR_F_PV +: 4], |e_sbe, |e_dbe, rq2_reg[`CDIR_RQ_SRC +: 3]};
      end

      // Arrays: read two clocks after acceptance, write back two later
      always @(posedge clock)
      begin
        if (init_clear)
        begin
          tag_mem[init_cnt_reg] <= {`CDIR_SET_WORD_W{1'b0}};
          vic_mem[init_cnt_reg] <= {`CDIR_VIC_WORD_W{1'b0}};
        end
        else if (v_reg[3])
        begin
          tag_mem[wr_set_reg] <= wr_word_reg;
          vic_mem[wr_set_reg] <= wr_vic_reg;
        end
        if (v_reg[1])
        begin
          rd_word_reg <= tag_mem[set1];
          rd_vic_reg <= vic_mem[set1];
        end
        if (v_reg[2])
        begin
          wr_word_reg <= new_word;
          wr_vic_reg <= new_vic;
          wr_set_reg <= set2;
        end
      end

      // Pipeline control and registered answer
      always @(posedge clock or negedge arst_n)
      begin
        if (!arst_n)
        begin
          v_reg <= 4'h0;
          rq0_reg <= {`CDIR_RQ_W{1'b0}};
          rq1_reg <= {`CDIR_RQ_W{1'b0}};
          rq2_reg <= {`CDIR_RQ_W{1'b0}};
          res_reg <= 63'h0;
          out_reg <= 63'h0;
          rv_reg <= 1'b0;
          sbe_reg <= 1'b0;
          dbe_reg <= 1'b0;
        end
        else
        begin
          v_reg <= {v_reg[2:0], acc};
          if (acc)
            rq0_reg <= sel_rq;
          rq1_reg <= rq0_reg;
          rq2_reg <= rq1_reg;
          if (v_reg[2])
            res_reg <= res_next;
          rv_reg <= v_reg[3];
          sbe_reg <= v_reg[3] & res_reg[4];
          dbe_reg <= v_reg[3] & res_reg[3];
          if (v_reg[3])
            out_reg <= res_reg;
        end
      end

      assign resp_valid[j] = rv_reg;
      assign ecc_sbe[j] = sbe_reg;
      assign ecc_dbe[j] = dbe_reg;
      assign resp_src[j*3 +: 3] = out_reg[2:0];
      assign resp_evict_pv[j*4 +: 4] = out_reg[8:5];
      assign resp_evict_addr[j*40 +: 40] = out_reg[48:9];
      assign resp_evict[j] = out_reg[49];
      assign resp_em[j] = out_reg[50];
      assign resp_pv[j*4 +: 4] = out_reg[54:51];
      assign resp_slot[j*7 +: 7] = out_reg[61:55];
      assign resp_hit[j] = out_reg[62];
    end
  endgenerate

endmodule // cdir_coherence_directory

/* File: hw/cdir_map.vh */
/*
  Constants of the coherence directory: geometry, address split, entry layout,
  request packing, operation codes, arbitration weights and timing counts.
  Assumes it is included by bare name into the design file that needs it.
*/
`ifndef CDIR_MAP_VH
`define CDIR_MAP_VH

// Requesters, interleaves and the geometry of one interleave
`define CDIR_NUM_REQ 5
`define CDIR_NUM_ILV 2
`define CDIR_NUM_GROUPS 8
`define CDIR_NUM_WAYS 16
`define CDIR_NUM_SETS 4096
`define CDIR_SET_W 12
`define CDIR_LAST_SET 12'hFFF
`define CDIR_SLOT_N 128
`define CDIR_ENT_W 35
`define CDIR_SET_WORD_W 4480
`define CDIR_VIC_W 8
`define CDIR_VIC_WORD_W 64
`define CDIR_ROM_IDX_W 10

// Physical address split (64-byte lines)
`define CDIR_ADDR_W 40
`define CDIR_LINE_W 6
`define CDIR_ILV_BIT 6
`define CDIR_SET_LSB 7
`define CDIR_TAG_LSB 19
`define CDIR_TAG_W 21

// Stored entry data before check bits
`define CDIR_DATA_W 28
`define CDIR_F_TAG 0
`define CDIR_F_PV 21
`define CDIR_F_EM 25
`define CDIR_PV_W 4

// Packed request carried down an interleave pipeline
`define CDIR_RQ_W 53
`define CDIR_RQ_SRC 0
`define CDIR_RQ_EM 3
`define CDIR_RQ_PV 4
`define CDIR_RQ_GRP 8
`define CDIR_RQ_ADDR 11
`define CDIR_RQ_OP 51

// Operation codes
`define CDIR_OP_LOOKUP 2'h0
`define CDIR_OP_UPDATE 2'h1
`define CDIR_OP_INVAL 2'h2

// Weighted round-robin: requesters 0..3 are processor buses, 4 is coherent I/O
`define CDIR_IO_REQ 3'h4
`define CDIR_WEIGHT_BUS 3'h2
`define CDIR_WEIGHT_IO 3'h1

// Timing: clock period in ns, latency in filter clocks (clock runs at twice the hub core rate)
`define CDIR_CLK_PERIOD_NS 20
`define CDIR_LOOKUP_LATENCY 4

`endif

/* File: sim/cdir_directory_sva.sv */
/*
  Checker on the coherence directory ports: grants, response timing per
  interleave, entry state on hits, error flags and the fast clear.
  Assumes one filter clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
module cdir_directory_sva (
  input wire clock,
  input wire arst_n,
  input wire [4:0] req_valid,
  input wire [199:0] req_addr,
  input wire [4:0] req_grant,
  input wire init_start,
  input wire init_busy,
  input wire [1:0] resp_valid,
  input wire [1:0] resp_hit,
  input wire [7:0] resp_pv,
  input wire [1:0] resp_em,
  input wire [1:0] resp_evict,
  input wire [79:0] resp_evict_addr,
  input wire [1:0] ecc_sbe,
  input wire [1:0] ecc_dbe
);
  // Interleave of each requester, from address bit six
  wire [4:0] ilv_sel = {req_addr[166], req_addr[126], req_addr[86], req_addr[46], req_addr[6]};
  wire g0 = |(req_grant & ~ilv_sel);
  wire g1 = |(req_grant & ilv_sel);
  reg [13:0] busy_cnt_reg;

  // Length of the running clear; zeroed between clears so a short one shows
  always @(posedge clock or negedge arst_n)
    if (!arst_n)
      busy_cnt_reg <= 14'h0000;
    else
      busy_cnt_reg <= init_busy ? busy_cnt_reg + 14'h0001 : 14'h0000;

  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  chk_grant_onehot: assert property ($onehot0(req_grant))
    else $error("more than one grant in a cycle");
  chk_grant_has_req: assert property (req_grant != 5'h00 |-> (req_grant & ~$past(req_valid)) == 5'h00)
    else $error("grant without a request");
  chk_no_grant_init: assert property ($past(init_busy) |-> req_grant == 5'h00)
    else $error("grant during clear");
  chk_lat_ilv0: assert property (g0 |-> ##4 resp_valid[0])
    else $error("interleave 0 answer late");
  chk_lat_ilv1: assert property (g1 |-> ##4 resp_valid[1])
    else $error("interleave 1 answer late");
  chk_resp_cause: assert property (resp_valid != 2'h0 |-> resp_valid == {$past(g1, 4), $past(g0, 4)})
    else $error("answer without grant four cycles back");
  chk_ilv_spacing: assert property (g0 |=> !g0)
    else $error("interleave 0 taken twice in a row");
  chk_em_single: assert property (resp_valid[0] && resp_hit[0] && resp_em[0] |-> $onehot(resp_pv[3:0]))
    else $error("owned flag with shared presence");
  chk_hit_present: assert property (resp_valid[1] && resp_hit[1] |-> resp_pv[7:4] != 4'h0)
    else $error("hit on an empty entry");
  chk_ecc_with_resp: assert property (((ecc_sbe | ecc_dbe) & ~resp_valid) == 2'h0)
    else $error("error flag without answer");
  chk_evict_line: assert property (resp_valid[0] && resp_evict[0] |-> resp_evict_addr[6:0] == 7'h00)
    else $error("evicted address not a line of interleave 0");
  chk_init_start: assert property (init_start |=> init_busy)
    else $error("clear did not start");
  chk_init_length: assert property ($fell(init_busy) |-> busy_cnt_reg >= 14'h1000)
    else $error("clear shorter than all sets");

  cov_io_grant: cover property (req_grant[4]);
  cov_evict: cover property (resp_valid[0] && resp_evict[0]);
  cov_hit: cover property (resp_valid[1] && resp_hit[1]);
  cov_init_done: cover property ($fell(init_busy));
endmodule // cdir_directory_sva

bind cdir_coherence_directory cdir_directory_sva u_chk (.clock(clock), .arst_n(arst_n),
  .req_valid(req_valid), .req_addr(req_addr), .req_grant(req_grant), .init_start(init_start),
  .init_busy(init_busy), .resp_valid(resp_valid), .resp_hit(resp_hit), .resp_pv(resp_pv),
  .resp_em(resp_em), .resp_evict(resp_evict), .resp_evict_addr(resp_evict_addr),
  .ecc_sbe(ecc_sbe), .ecc_dbe(ecc_dbe));

/* File: sim/cdir_engine_model.sv */
/*
  Protocol engine model: one request slot per requester, loaded by the bench,
  held until its grant is seen, then released.
  Assumes the bench loads a slot only while it is free.
*/
`timescale 1ns/100ps
module cdir_engine_model (
  input wire clock,
  input wire arst_n,
  input wire cmd_load,
  input wire [2:0] cmd_src,
  input wire [1:0] cmd_op,
  input wire [39:0] cmd_addr,
  input wire [2:0] cmd_group,
  input wire [3:0] cmd_pv,
  input wire cmd_em,
  input wire [4:0] req_grant,
  output reg [4:0] req_valid,
  output reg [9:0] req_op,
  output reg [199:0] req_addr,
  output reg [14:0] req_group,
  output reg [19:0] req_pv,
  output reg [4:0] req_em
);
  integer i;

  // A released slot shows inverted address and op fields so stale values are never trusted
  always @(posedge clock or negedge arst_n)
    if (!arst_n)
    begin
      req_valid <= 5'h00;
      req_op <= 10'h000;
      req_addr <= 200'h0;
      req_group <= 15'h0000;
      req_pv <= 20'h00000;
      req_em <= 5'h00;
    end
    else
    begin
      for (i = 0; i < 5; i = i + 1)
        if (req_grant[i])
        begin
          req_valid[i] <= 1'b0;
          req_addr[40*i+:40] <= ~req_addr[40*i+:40];
          req_op[2*i+:2] <= ~req_op[2*i+:2];
        end
      if (cmd_load)
      begin
        req_valid[cmd_src] <= 1'b1;
        req_op[2*cmd_src+:2] <= cmd_op;
        req_addr[40*cmd_src+:40] <= cmd_addr;
        req_group[3*cmd_src+:3] <= cmd_group;
        req_pv[4*cmd_src+:4] <= cmd_pv;
        req_em[cmd_src] <= cmd_em;
      end
    end
endmodule // cdir_engine_model

/* File: sim/tb_coherency_snoop_filter.sv */
/*
  Self-checking bench for the coherence directory: clear, add, lookup,
  invalidate, eviction, arbitration burst and random traffic.
  Assumes the engine model in the same folder and the map header on the path.
*/
`timescale 1ns/100ps
`include "cdir_map.vh"
module tb_coherency_snoop_filter;
  reg clock = 1'b0;
  reg arst_n = 1'b0;
  reg init_start = 1'b0;
  reg cmd_load = 1'b0;
  reg [2:0] cmd_src = 3'h0;
  reg [1:0] cmd_op = 2'h0;
  reg [39:0] cmd_addr = 40'h0;
  reg [2:0] cmd_group = 3'h0;
  reg [3:0] cmd_pv = 4'h0;
  reg cmd_em = 1'b0;
  wire [4:0] req_valid, req_em, req_grant;
  wire [9:0] req_op;
  wire [199:0] req_addr;
  wire [14:0] req_group;
  wire [19:0] req_pv;
  wire init_busy;
  wire [1:0] resp_valid, resp_hit, resp_em, resp_evict, ecc_sbe, ecc_dbe;
  wire [5:0] resp_src;
  wire [7:0] resp_pv;
  wire [13:0] resp_slot;
  wire [79:0] resp_evict_addr;
  wire [7:0] resp_evict_pv;
  integer mismatches = 0;
  integer n_tests = 0;
  logic [11:0] exp_q[$];

  always #10 clock = ~clock;

  cdir_engine_model u_eng (.clock(clock), .arst_n(arst_n), .cmd_load(cmd_load),
    .cmd_src(cmd_src), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_group(cmd_group),
    .cmd_pv(cmd_pv), .cmd_em(cmd_em), .req_grant(req_grant), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_group(req_group), .req_pv(req_pv),
    .req_em(req_em));
  cdir_coherence_directory DUT (.clock(clock), .arst_n(arst_n), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_group(req_group), .req_pv(req_pv),
    .req_em(req_em), .req_grant(req_grant), .init_start(init_start), .init_busy(init_busy),
    .resp_valid(resp_valid), .resp_src(resp_src), .resp_hit(resp_hit), .resp_slot(resp_slot),
    .resp_pv(resp_pv), .resp_em(resp_em), .resp_evict(resp_evict),
    .resp_evict_addr(resp_evict_addr), .resp_evict_pv(resp_evict_pv), .ecc_sbe(ecc_sbe),
    .ecc_dbe(ecc_dbe));

  task test_done;
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task check(input string nm, input [7:0] ex, input [7:0] got);
    n_tests++;
    if (ex !== got)
    begin
      $display("mismatch %s expected %h seen %h", nm, ex, got);
      mismatches++;
    end
  endtask

  function [39:0] mk(input [20:0] t, input [11:0] s, input il);
    mk = {t, s, il, 6'h00};
  endfunction

  // Note layout: {interleave, source, check evict, em (evict on a miss), pv, hit}
  // The load strobe stays up after a send and drops only while waiting
  task send(input [2:0] s, input [1:0] op, input [39:0] a, input [2:0] g, input [3:0] pv,
    input em, input [6:0] ex);
    integer k;
    k = 0;
    while (req_valid[s] !== 1'b0 && k < 300)
    begin
      cmd_load = 1'b0;
      @(posedge clock) #1;
      k++;
    end
    if (req_valid[s] !== 1'b0)
    begin
      mismatches++;
      test_done;
    end
    exp_q.push_back({a[6], s, ex});
    {cmd_src, cmd_op, cmd_addr, cmd_group, cmd_pv, cmd_em} = {s, op, a, g, pv, em};
    cmd_load = 1'b1;
    @(posedge clock) #1;
  endtask

  // Every answer must be settled before dependent traffic goes out
  task wait_idle;
    integer k;
    k = 0;
    cmd_load = 1'b0;
    while ((exp_q.size() != 0 || req_valid !== 5'h00) && k < 6000)
    begin
      @(posedge clock) #1;
      k++;
    end
    if (exp_q.size() != 0 || req_valid !== 5'h00)
    begin
      mismatches++;
      test_done;
    end
  endtask

  // Answers of one source come in order; sources may interleave after arbitration
  always @(negedge clock)
  begin : watch
    integer il, j, f;
    reg [11:0] e;
    reg [3:0] xp;
    for (il = 0; il < 2; il++)
      if (resp_valid[il] === 1'b1)
      begin
        f = -1;
        for (j = exp_q.size() - 1; j >= 0; j--)
          if (exp_q[j][9:7] === resp_src[3*il+:3])
            f = j;
        if (f < 0)
          check("resp_src", 8'hFF, {5'h00, resp_src[3*il+:3]});
        else
        begin
          e = exp_q[f];
          exp_q.delete(f);
          check("interleave", {7'h00, e[10]}, il[7:0]);
          check("resp_hit", {7'h00, e[0]}, {7'h00, resp_hit[il]});
          if (e[0])
            check("resp_state", {3'h0, e[5:1]}, {3'h0, resp_em[il], resp_pv[4*il+:4]});
          else
            check("resp_slot", 8'h00, {1'b0, resp_slot[7*il+:7]});
          // A hit never evicts, so bit five then carries only the flag
          if (e[6])
            check("resp_evict", {7'h00, e[5] & ~e[0]}, {7'h00, resp_evict[il]});
          // Only the full-group scenario evicts: set 9, presence bit follows the tag
          if (resp_evict[il] === 1'b1)
          begin
            xp = 4'h1 << resp_evict_addr[40*il+19+:2];
            check("resp_evict_pv", {4'h0, xp}, {4'h0, resp_evict_pv[4*il+:4]});
            check("evict_set", 8'h09, resp_evict_addr[40*il+7+:8]);
          end
          check("ecc_flags", 8'h00, {6'h00, ecc_sbe[il], ecc_dbe[il]});
        end
      end
  end

  initial
  begin : main
    integer b, n;
    reg [31:0] r;
    reg [39:0] a;
    reg [2:0] s;
    reg [3:0] p;
    r = $urandom(32'h862A094A);
    repeat (20) @(posedge clock);
    #1 arst_n = 1'b1;
    @(posedge clock) #1 init_start = 1'b1;
    @(posedge clock) #1 init_start = 1'b0;
    send(0, `CDIR_OP_LOOKUP, mk(21'h1, 12'h5, 1'b0), 3'h0, 4'h0, 1'b0, 7'h00);
    wait_idle;
    for (b = 0; b < 4; b++)
    begin
      a = mk(21'h1 + b[20:0], 12'h5, b[0]);
      send(b[2:0], `CDIR_OP_UPDATE, a, b[2:0], 4'h1 << b, 1'b1, 7'h40);
      wait_idle;
      send({1'b0, b[1:0] + 2'h1}, `CDIR_OP_LOOKUP, a, 3'h7, 4'h0, 1'b0, {2'h1, 4'h1 << b, 1'b1});
    end
    wait_idle;
    send(0, `CDIR_OP_UPDATE, mk(21'h1, 12'h5, 1'b0), 3'h0, 4'h5, 1'b1, 7'h63);
    wait_idle;
    send(2, `CDIR_OP_LOOKUP, mk(21'h1, 12'h5, 1'b0), 3'h2, 4'h0, 1'b0, 7'h0B);
    send(1, `CDIR_OP_INVAL, mk(21'h2, 12'h5, 1'b1), 3'h1, 4'h0, 1'b0, 7'h25);
    wait_idle;
    send(3, `CDIR_OP_LOOKUP, mk(21'h2, 12'h5, 1'b1), 3'h3, 4'h0, 1'b0, 7'h00);
    send(2, `CDIR_OP_UPDATE, mk(21'h3, 12'h5, 1'b0), 3'h2, 4'h0, 1'b1, 7'h69);
    wait_idle;
    send(0, `CDIR_OP_LOOKUP, mk(21'h3, 12'h5, 1'b0), 3'h0, 4'h0, 1'b0, 7'h00);
    send(4, `CDIR_OP_UPDATE, mk(21'h77, 12'h6, 1'b1), 3'h7, 4'h8, 1'b0, 7'h40);
    wait_idle;
    send(4, `CDIR_OP_LOOKUP, mk(21'h77, 12'h6, 1'b1), 3'h7, 4'h0, 1'b0, 7'h11);
    for (n = 0; n < 17; n++)
    begin
      if (n == 16)
        wait_idle;
      send({1'b0, n[1:0]}, `CDIR_OP_UPDATE, mk(21'h100 + n[20:0], 12'h9, 1'b0), 3'h3,
        4'h1 << n[1:0], 1'b0, {1'b1, n == 16, 5'h00});
    end
    wait_idle;
    for (n = 0; n < 5; n++)
      send(n[2:0], `CDIR_OP_LOOKUP, mk(21'h200, 12'h20 + n[11:0], n[0]), 3'h0, 4'h0, 1'b0,
        7'h00);
    for (n = 0; n < 24; n++)
    begin
      wait_idle;
      r = $urandom;
      a = mk(r[20:0], {1'b1, r[31:21]}, r[0]);
      r = $urandom;
      s = (r[2:0] > 3'h4) ? {1'b0, r[1:0]} : r[2:0];
      p = (r[7:4] == 4'h0) ? 4'h1 : r[7:4];
      send(s, `CDIR_OP_UPDATE, a, r[10:8], p, r[11], 7'h40);
      wait_idle;
      send(3'h4 - s, `CDIR_OP_LOOKUP, a, 3'h0, 4'h0, 1'b0,
        {1'b0, r[11] && ((p & (p - 4'h1)) == 4'h0), p, 1'b1});
    end
    wait_idle;
    test_done;
  end
endmodule // tb_coherency_snoop_filter
